// ### meter_regs_pkg.sv
// Constants, field layout and carriers for the metering register bank.
// Assumes a Modbus-RTU framing engine outside that hands over one register word per request.
//
// Operation
// - Configuration word resets to 0x0105
// - Default decodes address 1, 8N1, 4800
// - High byte holds station address 1-255
// - Station address zero means broadcast
// - Low byte top two bits pick format
// - Format codes 8N1, 8E1, 8O1, 8N2
// - Low nibble codes 3-6 pick 1200-9600
// - Configuration read by 03, written by 10
// - Identity and range words read-only, 03
// - Voltage range word reads 250
// - Current range word reads 50
// - Measurement words read-only through 03
// - Voltage in hundredths of a volt
// - Current in hundredths of an ampere
// - Active power in whole watts
// - Energy two words, 3200 counts per kWh
// - Power factor in thousandths
// - Direction reads 0 positive, 1 negative
// - Frequency in hundredths of a hertz
// - Sixteen-bit words, high byte first
// - Bad register address answers code 82
// - Out-of-range write answers code 83
// - Energy counters survive power loss
package meter_regs_pkg;

   localparam int CLOCK_HZ = 125_000_000;

   // Function and exception codes
   localparam logic [7:0] FUNC_READ = 8'h03;
   localparam logic [7:0] FUNC_WRITE = 8'h10;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h81;
   localparam logic [7:0] EXC_ADDR = 8'h82;
   localparam logic [7:0] EXC_VALUE = 8'h83;

   // Register offsets
   localparam logic [15:0] OFS_MODEL_ID_FIRST = 16'h0000;
   localparam logic [15:0] OFS_MODEL_ID_SECOND = 16'h0001;
   localparam logic [15:0] OFS_VOLTAGE_RANGE = 16'h0002;
   localparam logic [15:0] OFS_CURRENT_RANGE = 16'h0003;
   localparam logic [15:0] OFS_STATION_AND_LINE_SETUP = 16'h0004;
   localparam logic [15:0] OFS_RMS_VOLTAGE = 16'h0048;
   localparam logic [15:0] OFS_RMS_CURRENT = 16'h0049;
   localparam logic [15:0] OFS_ACTIVE_POWER = 16'h004a;
   localparam logic [15:0] OFS_FORWARD_ENERGY_WORD_A = 16'h004b;
   localparam logic [15:0] OFS_FORWARD_ENERGY_WORD_B = 16'h004c;
   localparam logic [15:0] OFS_POWER_FACTOR = 16'h004d;
   localparam logic [15:0] OFS_REVERSE_ENERGY_WORD_A = 16'h004e;
   localparam logic [15:0] OFS_REVERSE_ENERGY_WORD_B = 16'h004f;
   localparam logic [15:0] OFS_POWER_FLOW_DIRECTION = 16'h0050;
   localparam logic [15:0] OFS_LINE_FREQUENCY = 16'h0051;

   // Fixed and reset values
   localparam logic [15:0] VOLTAGE_RANGE_VALUE = 16'h00fa;
   localparam logic [15:0] CURRENT_RANGE_VALUE = 16'h0032;
   localparam logic [15:0] SETUP_RESET = 16'h0105;
   localparam logic [7:0] BROADCAST_STATION = 8'h00;

   // Field positions in the setup word
   localparam int STATION_LSB = 8;
   localparam int FORMAT_LSB = 6;
   localparam int RATE_LSB = 0;

   // Rate codes
   localparam logic [3:0] RATE_1200 = 4'h3;
   localparam logic [3:0] RATE_2400 = 4'h4;
   localparam logic [3:0] RATE_4800 = 4'h5;
   localparam logic [3:0] RATE_9600 = 4'h6;
   localparam int BAUD_1200 = 1200;
   localparam int BAUD_2400 = 2400;
   localparam int BAUD_4800 = 4800;
   localparam int BAUD_9600 = 9600;

   // Character length in bit times
   localparam logic [3:0] CHAR_BITS_SHORT = 4'ha;
   localparam logic [3:0] CHAR_BITS_LONG = 4'hb;

   typedef enum logic [1:0] {
      FORMAT_8N1 = 2'b00,
      FORMAT_8E1 = 2'b01,
      FORMAT_8O1 = 2'b10,
      FORMAT_8N2 = 2'b11
   } char_format_e;

   typedef struct packed {
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic [7:0] exc;
      logic [15:0] rdata;
   } reg_rsp_s;

   typedef struct packed {
      logic [15:0] voltage;
      logic [15:0] current;
      logic [15:0] power;
      logic [31:0] forward_energy;
      logic [15:0] power_factor;
      logic [31:0] reverse_energy;
      logic negative_flow;
      logic [15:0] frequency;
   } meas_s;

   typedef struct packed {
      logic [7:0] station;
      char_format_e format;
      logic [3:0] rate_code;
      logic [3:0] char_bits;
      logic parity_on;
      logic parity_odd;
      logic two_stop;
      logic [23:0] bit_cycles;
   } line_setup_s;

endpackage : meter_regs_pkg

// ### meter_modbus_register_map.sv
// Holding-register bank of a single-phase metering module.
// Assumes a framing engine that checks CRC, splits multi-word accesses into single words,
// and pulses rsp_sent once the answer frame has left the line.
`timescale 1ns/1ps
`default_nettype none

module meter_modbus_register_map
   import meter_regs_pkg::*;
#(
   parameter logic [15:0] MODEL_ID_FIRST = 16'h0a5a,  // Arbitrary value
   parameter logic [15:0] MODEL_ID_SECOND = 16'h05a5  // Arbitrary value
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Word request from the framing engine
   input wire logic req_valid,
   input var reg_req_s req,
   // Word answer
   output logic rsp_valid,
   output reg_rsp_s rsp,
   // Answer frame finished on the line
   input wire logic rsp_sent,
   // Station check for an incoming frame
   input wire logic [7:0] frame_station,
   output logic frame_for_us,
   output logic frame_broadcast,
   // Metering front end
   input var meas_s meas,
   // Active line setup
   output line_setup_s line_setup
);

   logic [15:0] setup;
   logic [15:0] pending_setup;
   logic pending;
   logic [15:0] fwd_low_shadow;
   logic [15:0] rev_low_shadow;
   logic [15:0] next_rdata;
   logic [7:0] next_exc;
   logic write_ok;
   logic [7:0] live_station;
   char_format_e live_format;
   logic [3:0] live_rate;
   logic [3:0] live_char_bits;
   logic live_parity_on;
   logic live_parity_odd;
   logic live_two_stop;
   logic [23:0] live_bit_cycles;

   function automatic logic rate_legal(input logic [3:0] code);
      rate_legal = (code >= RATE_1200) && (code <= RATE_9600);
   endfunction : rate_legal

   function automatic logic [23:0] cycles_per_bit(input logic [3:0] code);
      case (code)
         RATE_1200: cycles_per_bit = 24'(CLOCK_HZ / BAUD_1200);
         RATE_2400: cycles_per_bit = 24'(CLOCK_HZ / BAUD_2400);
         RATE_9600: cycles_per_bit = 24'(CLOCK_HZ / BAUD_9600);
         default: cycles_per_bit = 24'(CLOCK_HZ / BAUD_4800);
      endcase
   endfunction : cycles_per_bit

   function automatic logic [7:0] station_of(input logic [15:0] value);
      station_of = value[STATION_LSB +: 8];
   endfunction : station_of

   function automatic char_format_e format_of(input logic [15:0] value);
      format_of = char_format_e'(value[FORMAT_LSB +: 2]);
   endfunction : format_of

   function automatic logic [3:0] rate_of(input logic [15:0] value);
      rate_of = value[RATE_LSB +: 4];
   endfunction : rate_of

   // Spare bits between format and rate must stay zero, or a later use would misread them
   function automatic logic setup_legal(input logic [15:0] value);
      setup_legal = rate_legal(rate_of(value))
         && (value[FORMAT_LSB - 1 -: 2] == 2'b00)
         && (station_of(value) != BROADCAST_STATION);
   endfunction : setup_legal

   function automatic logic [3:0] char_bits_of(input char_format_e code);
      case (code)
         FORMAT_8N1: char_bits_of = CHAR_BITS_SHORT;
         default: char_bits_of = CHAR_BITS_LONG;
      endcase
   endfunction : char_bits_of

   function automatic logic parity_on_of(input char_format_e code);
      parity_on_of = (code == FORMAT_8E1) || (code == FORMAT_8O1);
   endfunction : parity_on_of

   function automatic logic parity_odd_of(input char_format_e code);
      parity_odd_of = (code == FORMAT_8O1);
   endfunction : parity_odd_of

   function automatic logic two_stop_of(input char_format_e code);
      two_stop_of = (code == FORMAT_8N2);
   endfunction : two_stop_of

   // Answer decode
   always_comb begin
      next_rdata = 16'h0000;
      next_exc = EXC_NONE;
      write_ok = 1'b0;
      if (req.func == FUNC_READ) begin
         if (req.addr == OFS_MODEL_ID_FIRST) begin
            next_rdata = MODEL_ID_FIRST;
         end else if (req.addr == OFS_MODEL_ID_SECOND) begin
            next_rdata = MODEL_ID_SECOND;
         end else if (req.addr == OFS_VOLTAGE_RANGE) begin
            next_rdata = VOLTAGE_RANGE_VALUE;
         end else if (req.addr == OFS_CURRENT_RANGE) begin
            next_rdata = CURRENT_RANGE_VALUE;
         end else if (req.addr == OFS_STATION_AND_LINE_SETUP) begin
            next_rdata = setup;
         end else if (req.addr == OFS_RMS_VOLTAGE) begin
            next_rdata = meas.voltage;
         end else if (req.addr == OFS_RMS_CURRENT) begin
            next_rdata = meas.current;
         end else if (req.addr == OFS_ACTIVE_POWER) begin
            next_rdata = meas.power;
         end else if (req.addr == OFS_FORWARD_ENERGY_WORD_A) begin
            next_rdata = meas.forward_energy[31:16];
         end else if (req.addr == OFS_FORWARD_ENERGY_WORD_B) begin
            next_rdata = fwd_low_shadow;
         end else if (req.addr == OFS_POWER_FACTOR) begin
            next_rdata = meas.power_factor;
         end else if (req.addr == OFS_REVERSE_ENERGY_WORD_A) begin
            next_rdata = meas.reverse_energy[31:16];
         end else if (req.addr == OFS_REVERSE_ENERGY_WORD_B) begin
            next_rdata = rev_low_shadow;
         end else if (req.addr == OFS_POWER_FLOW_DIRECTION) begin
            next_rdata = {15'h0000, meas.negative_flow};
         end else if (req.addr == OFS_LINE_FREQUENCY) begin
            next_rdata = meas.frequency;
         end else begin
            next_exc = EXC_ADDR;
         end
      end else if (req.func == FUNC_WRITE) begin
         if (req.addr != OFS_STATION_AND_LINE_SETUP) begin
            next_exc = EXC_ADDR;
         end else if (!setup_legal(req.wdata)) begin
            next_exc = EXC_VALUE;
         end else begin
            write_ok = 1'b1;
         end
      end else begin
         next_exc = EXC_FUNC;
      end
   end

   // Answer strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= req_valid;
      end
   end

   // Answer word holds until the next request
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rsp <= '0;
      end else begin
         if (req_valid) begin
            rsp.rdata <= next_rdata;
            rsp.exc <= next_exc;
         end
      end
   end

   // Low energy halves frozen when the upper half is read, so a paired read is coherent
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fwd_low_shadow <= 16'h0000;
      end else begin
         if (req_valid && req.func == FUNC_READ && req.addr == OFS_FORWARD_ENERGY_WORD_A) begin
            fwd_low_shadow <= meas.forward_energy[15:0];
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rev_low_shadow <= 16'h0000;
      end else begin
         if (req_valid && req.func == FUNC_READ && req.addr == OFS_REVERSE_ENERGY_WORD_A) begin
            rev_low_shadow <= meas.reverse_energy[15:0];
         end
      end
   end

   // Setup word; a write is parked until its answer has gone out
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         setup <= SETUP_RESET;
      end else begin
         if (pending && rsp_sent) begin
            setup <= pending_setup;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pending_setup <= SETUP_RESET;
      end else begin
         if (req_valid && write_ok) begin
            pending_setup <= req.wdata;
         end
      end
   end

   // A write that meets the send pulse wins, so it is not lost
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pending <= 1'b0;
      end else begin
         if (req_valid && write_ok) begin
            pending <= 1'b1;
         end else if (rsp_sent) begin
            pending <= 1'b0;
         end
      end
   end

   // Station match
   always_comb begin
      frame_broadcast = (frame_station == BROADCAST_STATION);
      frame_for_us = frame_broadcast || (frame_station == station_of(setup));
   end

   // Line setup, one register per field, one cycle behind the setup word
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_station <= SETUP_RESET[STATION_LSB +: 8];
      end else begin
         live_station <= station_of(setup);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_format <= char_format_e'(SETUP_RESET[FORMAT_LSB +: 2]);
      end else begin
         live_format <= format_of(setup);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_rate <= SETUP_RESET[RATE_LSB +: 4];
      end else begin
         live_rate <= rate_of(setup);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_char_bits <= CHAR_BITS_SHORT;
      end else begin
         live_char_bits <= char_bits_of(format_of(setup));
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_parity_on <= 1'b0;
      end else begin
         live_parity_on <= parity_on_of(format_of(setup));
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_parity_odd <= 1'b0;
      end else begin
         live_parity_odd <= parity_odd_of(format_of(setup));
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_two_stop <= 1'b0;
      end else begin
         live_two_stop <= two_stop_of(format_of(setup));
      end
   end

   // Reset rate code selects 4800
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         live_bit_cycles <= 24'(CLOCK_HZ / BAUD_4800);
      end else begin
         live_bit_cycles <= cycles_per_bit(rate_of(setup));
      end
   end

   always_comb begin
      line_setup.station = live_station;
      line_setup.format = live_format;
      line_setup.rate_code = live_rate;
      line_setup.char_bits = live_char_bits;
      line_setup.parity_on = live_parity_on;
      line_setup.parity_odd = live_parity_odd;
      line_setup.two_stop = live_two_stop;
      line_setup.bit_cycles = live_bit_cycles;
   end

   // Energy retention lives in the front end's nonvolatile store; the bank only mirrors it

endmodule : meter_modbus_register_map

`default_nettype wire

// ### meter_regs_asserts.sv
// Checker for the metering register bank word port.
// Assumes only the bank's own ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module meter_regs_asserts
   import meter_regs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Word port
   input wire logic req_valid,
   input var reg_req_s req,
   input wire logic rsp_valid,
   input var reg_rsp_s rsp,
   input wire logic rsp_sent,
   // Station check and front end
   input wire logic [7:0] frame_station,
   input wire logic frame_for_us,
   input wire logic frame_broadcast,
   input var meas_s meas,
   input var line_setup_s line_setup
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   wire logic rd = req_valid && req.func == FUNC_READ;

   a_answer_next: assert property (req_valid |=> rsp_valid)
      else $error("missing answer");
   a_no_stray: assert property (!req_valid |=> !rsp_valid)
      else $error("answer without request");
   a_voltage_read: assert property (rd && req.addr == OFS_RMS_VOLTAGE |=>
      rsp.rdata == $past(meas.voltage) && rsp.exc == EXC_NONE) else $error("voltage word");
   a_volt_range: assert property (rd && req.addr == OFS_VOLTAGE_RANGE |=>
      rsp.rdata == 16'h00fa) else $error("voltage range word");
   a_cur_range: assert property (rd && req.addr == OFS_CURRENT_RANGE |=>
      rsp.rdata == 16'h0032) else $error("current range word");
   a_direction_read: assert property (rd && req.addr == OFS_POWER_FLOW_DIRECTION |=>
      rsp.rdata == {15'h0000, $past(meas.negative_flow)}) else $error("direction word");
   a_rom_write: assert property (req_valid && req.func == FUNC_WRITE && req.addr < 16'h0004
      |=> rsp.exc == EXC_ADDR) else $error("fixed word took a write");
   a_gap_read: assert property (rd && (req.addr > 16'h0051 ||
      (req.addr > 16'h0004 && req.addr < 16'h0048)) |=> rsp.exc == EXC_ADDR)
      else $error("unmapped read not refused");
   a_broadcast_hit: assert property (frame_station == 8'h00 |->
      frame_for_us && frame_broadcast) else $error("broadcast missed");
endmodule : meter_regs_asserts

bind meter_modbus_register_map meter_regs_asserts u_chk (.clock(clock), .rstn(rstn),
   .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .rsp_sent(rsp_sent),
   .frame_station(frame_station), .frame_for_us(frame_for_us),
   .frame_broadcast(frame_broadcast), .meas(meas), .line_setup(line_setup));
`default_nettype wire

// ### modbus_host_model.sv
// Framing-engine model: one request per register word, then frame done.
// Assumes the bank answers one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
module modbus_host_model
   import meter_regs_pkg::*;
(
   // Clock
   input wire logic clock,
   // Word port
   output logic req_valid,
   output reg_req_s req,
   output logic rsp_sent
);
   initial begin
      req_valid = 1'b0;
      req = '1;
      rsp_sent = 1'b0;
   end
   // Byte order on the line is the framer's; here words go whole
   task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      #1;
      req_valid = 1'b1;
      req = '{f, a, d};
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      req = ~req; // Released fields never keep the last value
   endtask : send
   // Slow answers hold the frame on the wire longer
   task automatic finish(input int slow);
      repeat (slow + 1) @(posedge clock);
      #1;
      rsp_sent = 1'b1;
      @(posedge clock);
      #1;
      rsp_sent = 1'b0;
   endtask : finish
endmodule : modbus_host_model
`default_nettype wire

// ### meter_modbus_register_map_test.sv
// Self-checking bench for the metering register bank.
// Assumes the host model file and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module meter_modbus_register_map_test import meter_regs_pkg::*;;
   logic clock;
   logic rstn;
   logic req_valid;
   reg_req_s req;
   logic rsp_valid;
   reg_rsp_s rsp;
   logic rsp_sent;
   logic [7:0] frame_station;
   logic frame_for_us;
   logic frame_broadcast;
   meas_s meas;
   line_setup_s line_setup;
   int bad_count;
   int checked;
   int cycles;
   int baud[4] = '{1200, 2400, 4800, 9600};
   logic [15:0] bad[4] = '{16'h0107, 16'h0102, 16'h0005, 16'h0135};
   logic [31:0] rnd;
   logic [24:0] notes[$];
   logic [24:0] note;
   logic [15:0] setup;
   logic [15:0] old;

   meter_modbus_register_map #(.MODEL_ID_FIRST(16'h1234), .MODEL_ID_SECOND(16'h4321)) u_dut (
      .clock(clock), .rstn(rstn), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
      .rsp(rsp), .rsp_sent(rsp_sent), .frame_station(frame_station),
      .frame_for_us(frame_for_us), .frame_broadcast(frame_broadcast), .meas(meas),
      .line_setup(line_setup));
   modbus_host_model u_host (.clock(clock), .req_valid(req_valid), .req(req),
      .rsp_sent(rsp_sent));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Top bit of a note says whether the data word matters
   task automatic word(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
         input logic [7:0] exc, input logic [15:0] exp);
      notes.push_back({f == FUNC_READ && exc == EXC_NONE, exc, exp});
      u_host.send(f, a, d);
   endtask : word

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (rsp_valid === 1'b1) begin
         note = (notes.size() > 0) ? notes.pop_front() : 25'h1ffffff;
         chk({rsp.exc, (note[24] ? rsp.rdata : note[15:0])}, note[23:0]);
      end
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   initial begin
      rstn = 1'b0;
      frame_station = 8'h01;
      meas = '0;
      rnd = 32'h65fb;
      repeat (6) @(posedge clock);
      #1;
      rstn = 1'b1;
      chk(line_setup, {8'h01, 2'b00, 4'h5, 4'ha, 3'b000, 24'd26041});
      word(FUNC_READ, 16'h0004, 16'h0, EXC_NONE, 16'h0105);
      word(FUNC_READ, 16'h0000, 16'h0, EXC_NONE, 16'h1234);
      word(FUNC_READ, 16'h0001, 16'h0, EXC_NONE, 16'h4321);
      word(FUNC_READ, 16'h0002, 16'h0, EXC_NONE, 16'h00fa);
      word(FUNC_READ, 16'h0003, 16'h0, EXC_NONE, 16'h0032);
      word(8'h04, 16'h0048, 16'h0, EXC_FUNC, 16'h0);
      word(FUNC_WRITE, 16'h0001, 16'h0, EXC_ADDR, 16'h0);
      word(FUNC_WRITE, 16'h0048, 16'h0, EXC_ADDR, 16'h0);
      word(FUNC_READ, 16'h0005, 16'h0, EXC_ADDR, 16'h0);
      word(FUNC_READ, 16'h0052, 16'h0, EXC_ADDR, 16'h0);
      repeat (3) begin
         for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            meas = {meas[112:0], rnd};
         end
         word(FUNC_READ, 16'h0048, 16'h0, EXC_NONE, meas.voltage);
         word(FUNC_READ, 16'h0049, 16'h0, EXC_NONE, meas.current);
         word(FUNC_READ, 16'h004a, 16'h0, EXC_NONE, meas.power);
         word(FUNC_READ, 16'h004b, 16'h0, EXC_NONE, meas.forward_energy[31:16]);
         word(FUNC_READ, 16'h004c, 16'h0, EXC_NONE, meas.forward_energy[15:0]);
         word(FUNC_READ, 16'h004d, 16'h0, EXC_NONE, meas.power_factor);
         word(FUNC_READ, 16'h004e, 16'h0, EXC_NONE, meas.reverse_energy[31:16]);
         word(FUNC_READ, 16'h004f, 16'h0, EXC_NONE, meas.reverse_energy[15:0]);
         word(FUNC_READ, 16'h0050, 16'h0, EXC_NONE, {15'h0, meas.negative_flow});
         word(FUNC_READ, 16'h0051, 16'h0, EXC_NONE, meas.frequency);
      end
      setup = 16'h0105;
      for (int f = 0; f < 4; f++) begin
         for (int r = 0; r < 4; r++) begin
            rnd = lfsr(rnd);
            old = setup;
            setup = {rnd[7:0] | 8'h02, f[1:0], 2'b00, 4'h3 + r[3:0]};
            word(FUNC_WRITE, 16'h0004, setup, EXC_NONE, 16'h0);
            word(FUNC_READ, 16'h0004, 16'h0, EXC_NONE, old);
            u_host.finish(f + r);
            word(FUNC_READ, 16'h0004, 16'h0, EXC_NONE, setup);
            chk(line_setup, {setup[15:6], setup[3:0], (f == 0 ? 4'ha : 4'hb),
               f == 1 || f == 2, f == 2, f == 3, 24'(125000000 / baud[r])});
            frame_station = setup[15:8];
            @(posedge clock) #1 chk(frame_for_us, 1'b1);
            frame_station = 8'h01;
            @(posedge clock) #1 chk({frame_for_us, frame_broadcast}, 2'b00);
         end
      end
      frame_station = 8'h00;
      @(posedge clock) #1 chk({frame_for_us, frame_broadcast}, 2'b11);
      foreach (bad[i]) word(FUNC_WRITE, 16'h0004, bad[i], EXC_VALUE, 16'h0);
      u_host.finish(0);
      word(FUNC_READ, 16'h0004, 16'h0, EXC_NONE, setup);
      @(posedge clock) #1 rstn = 1'b0;
      @(posedge clock) #1 rstn = 1'b1;
      chk(line_setup, {8'h01, 2'b00, 4'h5, 4'ha, 3'b000, 24'd26041});
      word(FUNC_READ, 16'h0004, 16'h0, EXC_NONE, 16'h0105);
      repeat (3) @(posedge clock);
      chk(notes.size(), 0);
      summarize();
   end
endmodule : meter_modbus_register_map_test
`default_nettype wire
